// ### design/clcd_cell_fetch.sv
// Maps a character code and row onto pattern memory and forms the dot row
`timescale 1ns/1ns
module clcd_cell_fetch
  import clcd_pkg::*;
(
  input  wire logic [7:0]       code,
  input  wire logic [2:0]       row,
  input  wire logic [7:0]       pat_data,
  input  wire logic             cursor_here,
  input  wire logic             cursor_on,
  input  wire logic             disp_on,
  output logic      [5:0]       pat_addr,
  output logic                  from_ram,
  output logic      [DOT_W-1:0] dots
);

  always_comb
  begin
    // Code bit 3 is not part of the address, so codes 0 and 8 alias
    from_ram = (code[7:4] == PAT_CODE_HI); // [RQ12]
    pat_addr = {code[2:0], row}; // [RQ7] [RQ8]
    // Bit 4 is the leftmost dot; a one lights the dot
    dots     = from_ram ? pat_data[DOT_W-1:0] : '0; // [RQ11] [RQ13]
    // Cursor line is ORed, never replaces pattern bits
    if (cursor_on && cursor_here && row == CURSOR_ROW)
    begin
      dots = dots | DOTS_ALL; // [RQ9]
    end
    if (!disp_on)
    begin
      dots = '0;
    end
  end

endmodule

// ### design/clcd_pkg.sv
// Shared constants and types for the character LCD reset and pattern block
package clcd_pkg;

  // Register port map: one bit of address selects instruction or data
  localparam logic       REG_INSTR    = 1'h0;
  localparam logic       REG_DATA     = 1'h1;

  // Memory sizes
  localparam int         TEXT_DEPTH   = 80;
  localparam int         PAT_DEPTH    = 64;
  localparam logic [6:0] TEXT_LAST    = 7'h4f;
  localparam logic [7:0] CHAR_SPACE   = 8'h20;
  localparam logic [6:0] AC_HOME      = 7'h00;

  // Reset values of mode fields
  localparam logic       RST_WIDTH8   = 1'h1;
  localparam logic       RST_TWOLINE  = 1'h0;
  localparam logic       RST_FONT11   = 1'h0;
  localparam logic       RST_DISP     = 1'h0;
  localparam logic       RST_CURSOR   = 1'h0;
  localparam logic       RST_BLINK    = 1'h0;
  localparam logic       RST_INC      = 1'h1;
  localparam logic       RST_SHIFT    = 1'h0;

  // Instruction opcode is the highest set bit of the instruction byte
  localparam int         OP_TEXTADDR  = 7;
  localparam int         OP_PATADDR   = 6;
  localparam int         OP_FUNC      = 5;
  localparam int         OP_MOVE      = 4;
  localparam int         OP_DISPCTL   = 3;
  localparam int         OP_ENTRY     = 2;
  localparam int         OP_HOME      = 1;
  localparam int         OP_CLEAR     = 0;

  // Field positions inside instructions
  localparam int         FN_WIDTH     = 4;
  localparam int         FN_LINES     = 3;
  localparam int         FN_FONT      = 2;
  localparam int         DC_DISP      = 2;
  localparam int         DC_CURSOR    = 1;
  localparam int         DC_BLINK     = 0;
  localparam int         EM_INC       = 1;
  localparam int         EM_SHIFT     = 0;
  localparam int         MV_DISPLAY   = 3;
  localparam int         MV_RIGHT     = 2;

  // Pattern memory layout
  localparam int         DOT_W        = 5;
  localparam logic [2:0] CURSOR_ROW   = 3'h7;
  localparam logic [3:0] PAT_CODE_HI  = 4'h0;
  localparam logic [4:0] DOTS_ALL     = 5'h1f;

  // Power-up busy time
  localparam int         T_POR_MS     = 40;
  localparam int         CLK_MHZ      = 125;
  localparam int         POR_CYCLES   = T_POR_MS * 1000 * CLK_MHZ;

  typedef enum {
    ST_CLEAR,
    ST_FUNC,
    ST_DISP,
    ST_ENTRY,
    ST_WAIT,
    ST_IDLE
  } clcd_state_t;

endpackage

// ### design/clcd_top.sv
// Character LCD controller core: power-up reset, instruction port, pattern scan
//
// Function
// RQ1: After reset the busy flag reads busy until the 40 ms power-up time has passed.
// RQ2: Power-up first fills the text memory with spaces and sets the address counter to 0.
// RQ3: Power-up selects 8-bit bus width, one-line mode and the 5x8 font.
// RQ4: Power-up leaves display, cursor and blinking off.
// RQ5: Power-up sets entry mode to increment by one with no display shift.
// RQ6: If power-up reset cannot run, the host initialises the controller by instructions.
// RQ7: Pattern address bits 5..3 come from character code bits 2..0.
// RQ8: Pattern address bits 2..0 pick the row within the character cell.
// RQ9: The eighth pattern row is ORed with the cursor.
// RQ10: The host keeps the eighth row of a pattern at zero where only the cursor should show.
// RQ11: Dot columns come from pattern data bits 4..0 with bit 4 leftmost.
// RQ12: Codes with bits 7..4 all zero fetch from pattern memory, bit 3 ignored.
// RQ13: A one in pattern data lights a dot and a zero leaves it dark.
// RQ14: In 8-bit mode each transfer carries all eight data bits at once.
// RQ15: Reset steps run in order and host instructions are ignored while busy.
//
// Our own choices: the address-and-strobe port and the address map.
`timescale 1ns/1ns
module clcd_top
  import clcd_pkg::*;
#(
  parameter int POR_COUNT = POR_CYCLES
)
(
  input  wire logic       sys_clk,
  input  wire logic       rstn,
  input  wire logic       reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  output logic            busy_flag,
  output logic      [6:0] address_counter,
  output logic            bus_width_select,
  output logic            two_line,
  output logic            font_5x11,
  output logic            disp_on,
  output logic            cursor_on,
  output logic            blink_on,
  output logic            entry_inc,
  output logic            entry_shift,
  output logic      [3:0] scan_pos,
  output logic      [2:0] scan_row,
  output logic      [7:0] scan_code,
  output logic            scan_from_ram,
  output logic      [4:0] scan_dots
);

  localparam int CW = $clog2(POR_COUNT + 1);
  localparam logic [CW-1:0] POR_LAST = CW'(POR_COUNT - 1);

  logic [7:0]  text_mem [TEXT_DEPTH];
  logic [7:0]  pat_mem  [PAT_DEPTH];

  clcd_state_t state_r, state_nxt;
  logic [CW-1:0] por_cnt_r, por_cnt_nxt;
  logic        por_r, por_nxt;
  logic        busy_r, busy_nxt;
  logic [6:0]  ac_r, ac_nxt;
  logic [6:0]  clr_idx_r, clr_idx_nxt;
  logic [6:0]  shift_r, shift_nxt;
  logic        pat_sel_r, pat_sel_nxt;
  logic [7:0]  rdata_r, rdata_nxt;
  logic        w8_r, w8_nxt, n_r, n_nxt, f_r, f_nxt;
  logic        d_r, d_nxt, c_r, c_nxt, b_r, b_nxt, id_r, id_nxt, s_r, s_nxt;
  logic        text_we, pat_we;
  logic [6:0]  text_waddr;
  logic [5:0]  pat_waddr;
  logic [7:0]  mem_wdata;
  logic [6:0]  ac_step;
  logic [2:0]  op;

  // Next address after a memory access, following the entry direction
  always_comb
  begin
    if (pat_sel_r)
    begin
      ac_step = {1'b0, id_r ? ac_r[5:0] + 6'h01 : ac_r[5:0] - 6'h01};
    end
    else if (id_r)
    begin
      ac_step = (ac_r >= TEXT_LAST) ? AC_HOME : ac_r + 7'h01;
    end
    else
    begin
      ac_step = (ac_r == AC_HOME) ? TEXT_LAST : ac_r - 7'h01;
    end
    op = 3'h0;
    for (int i = 0; i < 8; i++)
    begin
      if (reg_wdata[i])
      begin
        op = 3'(i);
      end
    end
  end

  always_comb
  begin
    state_nxt   = state_r;
    por_cnt_nxt = por_cnt_r;
    por_nxt     = por_r;
    busy_nxt    = busy_r;
    ac_nxt      = ac_r;
    clr_idx_nxt = clr_idx_r;
    shift_nxt   = shift_r;
    pat_sel_nxt = pat_sel_r;
    rdata_nxt   = 8'h00;
    {w8_nxt, n_nxt, f_nxt} = {w8_r, n_r, f_r};
    {d_nxt, c_nxt, b_nxt, id_nxt, s_nxt} = {d_r, c_r, b_r, id_r, s_r};
    text_we     = 1'b0;
    pat_we      = 1'b0;
    text_waddr  = ac_r;
    pat_waddr   = ac_r[5:0];
    mem_wdata   = reg_wdata; // [RQ14]
    // Power-up time counts from reset release, across all init steps
    if (por_r && por_cnt_r != POR_LAST)
    begin
      por_cnt_nxt = por_cnt_r + CW'(1);
    end
    // Status is readable even while busy, so the host can poll
    if (reg_rd && reg_addr == REG_INSTR)
    begin
      rdata_nxt = {busy_r, ac_r};
    end
    case (state_r)
      ST_CLEAR:
      begin
        text_we     = 1'b1; // [RQ2]
        text_waddr  = clr_idx_r;
        mem_wdata   = CHAR_SPACE;
        clr_idx_nxt = clr_idx_r + 7'h01;
        if (clr_idx_r == TEXT_LAST)
        begin
          ac_nxt      = AC_HOME; // [RQ2]
          id_nxt      = RST_INC;
          shift_nxt   = 7'h00;
          pat_sel_nxt = 1'b0;
          clr_idx_nxt = 7'h00;
          state_nxt   = por_r ? ST_FUNC : ST_IDLE; // [RQ15]
          busy_nxt    = por_r;
        end
      end
      ST_FUNC:
      begin
        {w8_nxt, n_nxt, f_nxt} = {RST_WIDTH8, RST_TWOLINE, RST_FONT11}; // [RQ3]
        state_nxt = ST_DISP; // [RQ15]
      end
      ST_DISP:
      begin
        {d_nxt, c_nxt, b_nxt} = {RST_DISP, RST_CURSOR, RST_BLINK}; // [RQ4]
        state_nxt = ST_ENTRY; // [RQ15]
      end
      ST_ENTRY:
      begin
        {id_nxt, s_nxt} = {RST_INC, RST_SHIFT}; // [RQ5]
        state_nxt = ST_WAIT; // [RQ15]
      end
      ST_WAIT:
      begin
        // Busy holds until the full power-up time has run out
        if (por_cnt_r == POR_LAST)
        begin
          por_nxt   = 1'b0;
          busy_nxt  = 1'b0; // [RQ1]
          state_nxt = ST_IDLE;
        end
      end
      ST_IDLE:
      begin
        if (reg_wr && reg_addr == REG_INSTR && reg_wdata != 8'h00)
        begin
          case (op)
            3'(OP_TEXTADDR):
            begin
              ac_nxt      = reg_wdata[6:0];
              pat_sel_nxt = 1'b0;
            end
            3'(OP_PATADDR):
            begin
              ac_nxt      = {1'b0, reg_wdata[5:0]};
              pat_sel_nxt = 1'b1;
            end
            3'(OP_FUNC):
            begin
              w8_nxt = reg_wdata[FN_WIDTH];
              n_nxt  = reg_wdata[FN_LINES];
              f_nxt  = reg_wdata[FN_FONT];
            end
            3'(OP_MOVE):
            begin
              if (reg_wdata[MV_DISPLAY])
              begin
                shift_nxt = reg_wdata[MV_RIGHT]
                          ? ((shift_r == AC_HOME) ? TEXT_LAST : shift_r - 7'h01)
                          : ((shift_r == TEXT_LAST) ? AC_HOME : shift_r + 7'h01);
              end
              else
              begin
                ac_nxt = reg_wdata[MV_RIGHT]
                       ? ((ac_r >= TEXT_LAST) ? AC_HOME : ac_r + 7'h01)
                       : ((ac_r == AC_HOME) ? TEXT_LAST : ac_r - 7'h01);
              end
            end
            3'(OP_DISPCTL):
            begin
              d_nxt = reg_wdata[DC_DISP];
              c_nxt = reg_wdata[DC_CURSOR];
              b_nxt = reg_wdata[DC_BLINK];
            end
            3'(OP_ENTRY):
            begin
              id_nxt = reg_wdata[EM_INC];
              s_nxt  = reg_wdata[EM_SHIFT];
            end
            3'(OP_HOME):
            begin
              ac_nxt      = AC_HOME;
              shift_nxt   = 7'h00;
              pat_sel_nxt = 1'b0;
            end
            default:
            begin
              state_nxt = ST_CLEAR;
              busy_nxt  = 1'b1;
            end
          endcase
        end
        else if (reg_wr && reg_addr == REG_DATA)
        begin
          text_we = !pat_sel_r; // [RQ14]
          pat_we  = pat_sel_r;
          ac_nxt  = ac_step;
          // Shift on text writes only, left when incrementing
          if (s_r && !pat_sel_r)
          begin
            shift_nxt = id_r ? ((shift_r == TEXT_LAST) ? AC_HOME : shift_r + 7'h01)
                             : ((shift_r == AC_HOME) ? TEXT_LAST : shift_r - 7'h01);
          end
        end
        else if (reg_rd && reg_addr == REG_DATA)
        begin
          rdata_nxt = pat_sel_r ? pat_mem[ac_r[5:0]] : text_mem[ac_r];
          ac_nxt    = ac_step;
        end
      end
      default:
      begin
        state_nxt = ST_CLEAR;
      end
    endcase
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rstn)
    begin
      state_r   <= ST_CLEAR;
      por_cnt_r <= '0;
      por_r     <= 1'b1;
      busy_r    <= 1'b1; // [RQ1]
      ac_r      <= AC_HOME;
      clr_idx_r <= 7'h00;
      shift_r   <= 7'h00;
      pat_sel_r <= 1'b0;
      rdata_r   <= 8'h00;
      {w8_r, n_r, f_r} <= {RST_WIDTH8, RST_TWOLINE, RST_FONT11};
      {d_r, c_r, b_r, id_r, s_r} <= {RST_DISP, RST_CURSOR, RST_BLINK, RST_INC, RST_SHIFT};
    end
    else
    begin
      state_r   <= state_nxt;
      por_cnt_r <= por_cnt_nxt;
      por_r     <= por_nxt;
      busy_r    <= busy_nxt;
      ac_r      <= ac_nxt;
      clr_idx_r <= clr_idx_nxt;
      shift_r   <= shift_nxt;
      pat_sel_r <= pat_sel_nxt;
      rdata_r   <= rdata_nxt;
      {w8_r, n_r, f_r} <= {w8_nxt, n_nxt, f_nxt};
      {d_r, c_r, b_r, id_r, s_r} <= {d_nxt, c_nxt, b_nxt, id_nxt, s_nxt};
    end
  end

  // Memory arrays carry no reset; power-up clear fills the text memory
  always_ff @(posedge sys_clk)
  begin
    if (text_we)
    begin
      text_mem[text_waddr] <= mem_wdata;
    end
    if (pat_we)
    begin
      pat_mem[pat_waddr] <= mem_wdata;
    end
  end

  // Display scan: one cell row per clock, 16 positions of 8 rows
  logic [3:0] pos_r, pos_nxt;
  logic [2:0] row_r, row_nxt;
  logic [6:0] cell_addr;
  logic [7:0] cell_code;
  logic [5:0] cell_pat_addr;
  logic       cell_from_ram;
  logic [4:0] cell_dots;

  always_comb
  begin
    row_nxt   = row_r + 3'h1;
    pos_nxt   = (row_r == CURSOR_ROW) ? pos_r + 4'h1 : pos_r;
    cell_addr = {3'h0, pos_r} + shift_r;
    if (cell_addr > TEXT_LAST)
    begin
      cell_addr = cell_addr - 7'(TEXT_DEPTH);
    end
    cell_code = text_mem[cell_addr];
  end

  clcd_cell_fetch u_fetch (
    .code        (cell_code),
    .row         (row_r),
    .pat_data    (pat_mem[cell_pat_addr]),
    .cursor_here (!pat_sel_r && cell_addr == ac_r),
    .cursor_on   (c_r),
    .disp_on     (d_r),
    .pat_addr    (cell_pat_addr),
    .from_ram    (cell_from_ram),
    .dots        (cell_dots)
  );

  always_ff @(posedge sys_clk)
  begin
    if (!rstn)
    begin
      pos_r         <= 4'h0;
      row_r         <= 3'h0;
      scan_pos      <= 4'h0;
      scan_row      <= 3'h0;
      scan_code     <= 8'h00;
      scan_from_ram <= 1'b0;
      scan_dots     <= 5'h00;
    end
    else
    begin
      pos_r         <= pos_nxt;
      row_r         <= row_nxt;
      scan_pos      <= pos_r;
      scan_row      <= row_r;
      scan_code     <= cell_code;
      scan_from_ram <= cell_from_ram;
      scan_dots     <= cell_dots;
    end
  end

  assign reg_rdata        = rdata_r;
  assign busy_flag        = busy_r;
  assign address_counter  = ac_r;
  assign bus_width_select = w8_r;
  assign two_line         = n_r;
  assign font_5x11        = f_r;
  assign disp_on          = d_r;
  assign cursor_on        = c_r;
  assign blink_on         = b_r;
  assign entry_inc        = id_r;
  assign entry_shift      = s_r;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);

  a_busy_during_por: assert property (por_r |-> busy_flag) // [RQ1]
    else $error("busy flag low during power-up");
  a_busy_por_len: assert property ($fell(busy_flag) && $past(por_r) |-> $past(por_cnt_r) == POR_LAST) // [RQ1]
    else $error("power-up busy ended early");
  a_clear_fill: assert property (state_r == ST_CLEAR |=> text_mem[$past(clr_idx_r)] == CHAR_SPACE) // [RQ2]
    else $error("clear did not write a space");
  a_clear_home: assert property (state_r == ST_CLEAR && clr_idx_r == TEXT_LAST |=> ac_r == AC_HOME) // [RQ2]
    else $error("clear did not home the address counter");
  a_init_order: assert property (state_r == ST_FUNC |=> state_r == ST_DISP ##1 state_r == ST_ENTRY ##1 state_r == ST_WAIT) // [RQ15]
    else $error("init steps out of order");
  a_func_reset: assert property (state_r == ST_DISP && por_r |-> bus_width_select && !two_line && !font_5x11) // [RQ3]
    else $error("function set defaults wrong");
  a_disp_reset: assert property (state_r == ST_ENTRY && por_r |-> !disp_on && !cursor_on && !blink_on) // [RQ4]
    else $error("display control defaults wrong");
  a_entry_reset: assert property (state_r == ST_WAIT |-> entry_inc && !entry_shift) // [RQ5]
    else $error("entry mode defaults wrong");
  a_busy_ignore: assert property (busy_r && state_r == ST_WAIT && reg_wr |=> $stable(ac_r) && $stable(disp_on)) // [RQ15]
    else $error("instruction taken while busy");
  // Text memory holds unknowns until the power-up clear has run
  a_pat_addr_map: assert property (!por_r |-> // [RQ7] [RQ8] [RQ12]
    cell_pat_addr == {cell_code[2:0], row_r} && cell_from_ram == (cell_code[7:4] == 4'h0))
    else $error("pattern address mapping wrong");
  a_cursor_or: assert property (d_r && c_r && cell_from_ram && !pat_sel_r && cell_addr == ac_r && row_r == CURSOR_ROW |=> scan_dots == DOTS_ALL) // [RQ9]
    else $error("cursor row not ORed");
  a_dots_from_ram: assert property (d_r && !c_r && cell_from_ram |=> scan_dots == $past(pat_mem[cell_pat_addr][4:0])) // [RQ11] [RQ13]
    else $error("dot row does not follow pattern data");
  a_text_write8: assert property (state_r == ST_IDLE && reg_wr && reg_addr == REG_DATA && !pat_sel_r |=> text_mem[$past(ac_r)] == $past(reg_wdata)) // [RQ14]
    else $error("data write lost bits");

  c_por_done: cover property (por_r ##1 !por_r);
  c_pat_write: cover property (state_r == ST_IDLE && reg_wr && reg_addr == REG_DATA && pat_sel_r);
  c_cursor_row: cover property (d_r && c_r && row_r == CURSOR_ROW && cell_addr == ac_r);

endmodule

// ### tb/clcd_host_model.sv
// Host processor model driving the instruction and data port
`timescale 1ns/1ns
module clcd_host_model (
  input  wire logic       sys_clk,
  input  wire logic [7:0] reg_rdata,
  output logic            reg_addr,
  output logic      [7:0] reg_wdata,
  output logic            reg_wr,
  output logic            reg_rd
);
  // Idle cycles inserted before each transfer, so the host can be slow as well as prompt
  int gap = 0;

  initial
  begin
    reg_addr  = 1'h0;
    reg_wdata = 8'h00;
    reg_wr    = 1'h0;
    reg_rd    = 1'h0;
  end

  // Whole byte on all eight lines in one strobe
  task automatic wr(input logic a, input logic [7:0] d);
    repeat (gap) @(posedge sys_clk);
    @(posedge sys_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'h1;
    @(posedge sys_clk);
    reg_wr    <= 1'h0;
    // Released lines do not keep the old value, so a stale sample shows up
    reg_wdata <= ~d;
    reg_addr  <= ~a;
    // Mode outputs update on the strobe's edge; let them settle before callers look
    @(negedge sys_clk);
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic a, output logic [7:0] d);
    repeat (gap) @(posedge sys_clk);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd   <= 1'h1;
    @(posedge sys_clk);
    reg_rd   <= 1'h0;
    reg_addr <= ~a;
    @(negedge sys_clk);
    d = reg_rdata;
  endtask
endmodule

// ### tb/testbench.sv
// Self-checking bench for the character LCD core: power-up, host init, pattern scan
`timescale 1ns/1ns
module testbench;
  import clcd_pkg::*;
  localparam int POR = 200;
  logic        sys_clk = 1'h0;
  logic        rstn = 1'h0;
  logic        reg_addr, reg_wr, reg_rd;
  logic  [7:0] reg_wdata, reg_rdata, scan_code;
  logic        busy_flag, bus_width_select, two_line, font_5x11;
  logic        disp_on, cursor_on, blink_on, entry_inc, entry_shift, scan_from_ram;
  logic  [6:0] address_counter;
  logic  [3:0] scan_pos;
  logic  [2:0] scan_row;
  logic  [4:0] scan_dots;
  int          error_cnt = 0;
  int          n_compared = 0;
  int          cyc = 0;
  logic  [7:0] text_m [80];
  logic  [7:0] pat_m [64];
  logic [31:0] seed = 32'h35;

  always #4 sys_clk = ~sys_clk;

  clcd_host_model u_host (.sys_clk(sys_clk), .reg_rdata(reg_rdata), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd));

  clcd_top #(.POR_COUNT(POR)) u_dut (.sys_clk(sys_clk), .rstn(rstn), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .busy_flag(busy_flag), .address_counter(address_counter),
    .bus_width_select(bus_width_select), .two_line(two_line), .font_5x11(font_5x11),
    .disp_on(disp_on), .cursor_on(cursor_on), .blink_on(blink_on), .entry_inc(entry_inc),
    .entry_shift(entry_shift), .scan_pos(scan_pos), .scan_row(scan_row),
    .scan_code(scan_code), .scan_from_ram(scan_from_ram), .scan_dots(scan_dots));

  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic end_of_test();
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // Hang guard sized well above the roughly 1300 cycles the sequence needs
  always @(posedge sys_clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      error_cnt++;
      end_of_test();
    end
  end

  task automatic chk_modes(input logic [2:0] fn, input logic [2:0] dc, input logic [1:0] em);
    chk("function", {bus_width_select, two_line, font_5x11}, fn);
    chk("display", {disp_on, cursor_on, blink_on}, dc);
    chk("entry", {entry_inc, entry_shift}, em);
  endtask

  task automatic wait_ready(input int lim, output int n);
    n = 0;
    while (busy_flag !== 1'h0 && n < lim)
    begin
      @(posedge sys_clk);
      n++;
    end
    chk("ready", busy_flag, 1'h0);
  endtask

  // Dot row from the model memories, compared cell by cell while the scan runs
  task automatic scan_chk(input int cycles);
    logic [7:0] code;
    logic [4:0] exp;
    repeat (cycles)
    begin
      @(negedge sys_clk);
      code = text_m[scan_pos];
      chk("scan_code", scan_code, code);
      chk("from_ram", scan_from_ram, code[7:4] == 4'h0);
      exp = (code[7:4] == 4'h0) ? pat_m[{code[2:0], scan_row}][4:0] : 5'h00;
      if (cursor_on && scan_row == 3'h7 && {3'h0, scan_pos} == address_counter)
        exp = exp | 5'h1f;
      if (!disp_on)
        exp = 5'h00;
      chk("dots", scan_dots, exp);
    end
  endtask

  initial
  begin
    logic [7:0] d;
    int         n;
    int         k;
    time        rel_t;
    repeat (2) @(posedge sys_clk);
    @(negedge sys_clk);
    chk("busy_in_reset", busy_flag, 1'h1);
    @(posedge sys_clk);
    rstn <= 1'h1;
    rel_t = $time;
    // Writes during busy must be dropped; the status read still answers
    u_host.wr(REG_DATA, 8'h55);
    u_host.wr(REG_INSTR, 8'h0f);
    u_host.rd(REG_INSTR, d);
    chk("status_busy", d[7], 1'h1);
    // A second refused instruction lands after the clear, in the long wait
    repeat (90) @(posedge sys_clk);
    u_host.wr(REG_INSTR, 8'h0f);
    wait_ready(1000, n);
    n = int'(($time - rel_t) / 8);
    chk("busy_time", (n >= POR - 2) && (n <= POR + 4), 1'h1);
    chk("ac_home", address_counter, 7'h00);
    chk_modes(3'b100, 3'b000, 2'b10);
    for (int i = 0; i < 80; i++)
    begin
      u_host.rd(REG_DATA, d);
      chk("text_clear", d, CHAR_SPACE);
      text_m[i] = CHAR_SPACE;
    end
    chk("ac_wrap", address_counter, 7'h00);
    $display("test power_up done");

    // Host-side initialisation, all four line and font combinations in 8-bit mode
    for (int i = 0; i < 4; i++)
    begin
      u_host.wr(REG_INSTR, 8'h30 | 8'(i << 2));
      chk("fn_set", {bus_width_select, two_line, font_5x11}, {1'b1, 2'(i)});
    end
    u_host.wr(REG_INSTR, 8'h30);
    u_host.wr(REG_INSTR, 8'h08);
    u_host.wr(REG_INSTR, 8'h06);
    chk_modes(3'b100, 3'b000, 2'b10);
    $display("test host_init done");

    // Patterns: rows 7 of the first four characters kept clear for a bare cursor
    u_host.wr(REG_INSTR, 8'h40);
    for (int i = 0; i < 64; i++)
    begin
      d = 8'(xs());
      if (i[2:0] == 3'h7 && i < 32)
        d = 8'h00;
      pat_m[i] = d;
      u_host.wr(REG_DATA, d);
    end
    for (int i = 0; i < 8; i++)
    begin
      k = int'(xs() & 32'h3f);
      u_host.wr(REG_INSTR, 8'h40 | 8'(k));
      u_host.rd(REG_DATA, d);
      chk("pat_read", d, pat_m[k]);
    end
    u_host.gap = 2;
    u_host.wr(REG_INSTR, 8'h80);
    for (int p = 0; p < 16; p++)
    begin
      d = (p < 14) ? 8'(p) : ((p == 14) ? 8'h10 : 8'h80);
      text_m[p] = d;
      u_host.wr(REG_DATA, d);
    end
    u_host.gap = 0;
    chk("ac_step", address_counter, 7'h10);
    u_host.wr(REG_INSTR, 8'h85);
    u_host.wr(REG_INSTR, 8'h0e);
    repeat (3) @(posedge sys_clk);
    scan_chk(300);
    u_host.wr(REG_INSTR, 8'h83);
    repeat (3) @(posedge sys_clk);
    scan_chk(140);
    u_host.wr(REG_INSTR, 8'h08);
    repeat (3) @(posedge sys_clk);
    scan_chk(130);
    $display("test pattern_scan done");

    // Clear instruction: busy again, text back to spaces, cursor home, increment
    u_host.wr(REG_INSTR, 8'h05);
    u_host.wr(REG_INSTR, 8'h01);
    u_host.rd(REG_INSTR, d);
    chk("clear_busy", d[7], 1'h1);
    wait_ready(200, n);
    chk("clear_ac", address_counter, 7'h00);
    chk("clear_entry", {entry_inc, entry_shift}, 2'b11);
    u_host.wr(REG_INSTR, 8'h8f);
    u_host.rd(REG_DATA, d);
    chk("clear_text", d, CHAR_SPACE);
    $display("test clear done");
    end_of_test();
  end
endmodule
